/* rtl/tzs_pkg.sv */
// Constants for the transmit zero suppression and robbed-bit insertion block.
// Assumes one 100 MHz clock and a byte-wide indirect register port.
package tzs_pkg;
  localparam int NUM_TS = 24;
  localparam int FRAMES_SF = 12;
  localparam int FRAMES_ESF = 24;
  // Register regions: channel control at index 0x00, signaling control at 0x40.
  localparam logic [7:0] CHAN_CTRL_BASE = 8'h00;
  localparam logic [7:0] SIG_CTRL_BASE = 8'h40;
  localparam logic [7:0] IFACE_CTRL_ADDR = 8'h20;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Channel control fields.
  localparam int ZCS_LSB = 4;
  // Signaling control fields.
  localparam int SIG_A_BIT = 7;
  localparam int SIG_B_BIT = 6;
  localparam int SIG_C_BIT = 5;
  localparam int SIG_D_BIT = 4;
  localparam int SIG_MODE_LSB = 0;
  // Interface control field.
  localparam int FRAC_BIT = 4;
  localparam logic [7:0] FIXED_OCTET = 8'h98;
  typedef enum logic [1:0] {
    TZS_ZCS_NONE = 2'h0,
    TZS_ZCS_BIT7 = 2'h1,
    TZS_ZCS_BIT8 = 2'h2,
    TZS_ZCS_FIXED = 2'h3
  } tzs_zcs_e;
  // Signaling modes in bits 1:0 of the signaling control register.
  typedef enum logic [1:0] {
    TZS_SIG_TRANSP = 2'h0,
    TZS_SIG_TWO = 2'h1,
    TZS_SIG_FOUR = 2'h2,
    TZS_SIG_SIXTEEN = 2'h3
  } tzs_sig_e;
  // Signaling source in bits 3:2 of the signaling control register.
  localparam int SRC_LSB = 2;
  localparam logic [1:0] SRC_REG = 2'h0;
  localparam logic [1:0] SRC_PIN = 2'h1;
  localparam logic [1:0] SRC_PCM = 2'h2;
  typedef enum logic [1:0] {
    TZS_FMT_N = 2'h0,
    TZS_FMT_SF = 2'h1,
    TZS_FMT_ESF = 2'h2
  } tzs_fmt_e;
endpackage : tzs_pkg

/* rtl/tzs_octet_if.sv */
// Octet hand-off between the serial front end, the buffer and the output.
// Assumes valid/ready transfer on the single block clock.
`timescale 1ns/1ps
`default_nettype none
interface tzs_octet_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic [4:0] slot;
  logic [4:0] frame;
  logic sig_bit;
  modport src (output valid, output data, output slot, output frame, output sig_bit, input ready);
  modport dst (input valid, input data, input slot, input frame, input sig_bit, output ready);
endinterface : tzs_octet_if
`default_nettype wire

/* rtl/tzs_skid_buf.sv */
// Two-entry buffer for captured octets with their timeslot and frame tags.
// Assumes source and sink share the block clock.
`timescale 1ns/1ps
`default_nettype none
module tzs_skid_buf #(
  parameter int DEPTH = 2,
  parameter int WIDTH = 19
) (
  input wire logic clock,
  input wire logic sys_rst,
  tzs_octet_if.dst in_if,
  tzs_octet_if.src out_if
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH != 2 || WIDTH != 19) begin : g_bad_cfg
    $error("tzs_skid_buf supports two entries of 19 bits only");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_if.valid && in_if.ready;
  wire pop = out_if.valid && out_if.ready;
  wire [WIDTH-1:0] head = mem_q[rd_q];
  assign in_if.ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_if.valid = (cnt_q != '0);
  assign out_if.data = head[7:0];
  assign out_if.slot = head[12:8];
  assign out_if.frame = head[17:13];
  assign out_if.sig_bit = head[18];
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= {in_if.sig_bit, in_if.frame, in_if.slot, in_if.data};
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tzs_skid_buf
`default_nettype wire

/* rtl/tzs_sig_stamp.sv */
// Robbed-bit insertion and zero code suppression for one buffered octet.
// Assumes register values are stable around the octet being released.
`timescale 1ns/1ps
`default_nettype none
module tzs_sig_stamp (
  input wire logic [7:0] octet,
  input wire logic [4:0] frame,
  input wire logic ext_bit,
  input wire logic [1:0] fmt,
  input wire logic [7:0] chan_ctrl,
  input wire logic [7:0] sig_ctrl,
  output logic [7:0] result
);
  wire [1:0] zcs = chan_ctrl[tzs_pkg::ZCS_LSB +: 2];
  wire [1:0] mode = sig_ctrl[tzs_pkg::SIG_MODE_LSB +: 2];
  wire [1:0] src = sig_ctrl[tzs_pkg::SRC_LSB +: 2];
  wire is_sf = (fmt == tzs_pkg::TZS_FMT_SF);
  wire is_esf = (fmt == tzs_pkg::TZS_FMT_ESF);
  wire f6 = (frame == 5'd5);
  wire f12 = (frame == 5'd11);
  wire f18 = (frame == 5'd17);
  wire f24 = (frame == 5'd23);
  // Frame counter is zero based, so frame 6 is count 5.
  wire sig_frame = (is_sf && (f6 || f12)) || (is_esf && (f6 || f12 || f18 || f24));
  wire bit_a = sig_ctrl[tzs_pkg::SIG_A_BIT];
  wire bit_b = sig_ctrl[tzs_pkg::SIG_B_BIT];
  wire bit_c = sig_ctrl[tzs_pkg::SIG_C_BIT];
  wire bit_d = sig_ctrl[tzs_pkg::SIG_D_BIT];
  logic reg_bit;
  always_comb begin
    reg_bit = bit_a;
    unique case (mode)
      tzs_pkg::TZS_SIG_TWO: reg_bit = bit_a;
      tzs_pkg::TZS_SIG_FOUR: reg_bit = (f12 || f24) ? bit_b : bit_a;
      tzs_pkg::TZS_SIG_SIXTEEN: begin
        // In superframe only A and B are reachable, so C and D are never used.
        if (is_sf) begin
          reg_bit = f12 ? bit_b : bit_a;
        end else begin
          reg_bit = f6 ? bit_a : f12 ? bit_b : f18 ? bit_c : bit_d;
        end
      end
      default: reg_bit = bit_a;
    endcase
  end
  // Embedded signaling from the PCM stream is left untouched.
  wire insert = sig_frame && (mode != tzs_pkg::TZS_SIG_TRANSP) && (src != tzs_pkg::SRC_PCM);
  wire sbit = (src == tzs_pkg::SRC_PIN) ? ext_bit : reg_bit;
  wire [7:0] signed_octet = insert ? {octet[7:1], sbit} : octet;
  wire all_zero = (octet == 8'h00);
  wire lsb_sig = insert ? sbit : octet[0];
  always_comb begin
    result = signed_octet;
    if (all_zero) begin
      unique case (zcs)
        tzs_pkg::TZS_ZCS_NONE: result = signed_octet;
        tzs_pkg::TZS_ZCS_BIT7: result = signed_octet | 8'h02;
        tzs_pkg::TZS_ZCS_BIT8: begin
          if (!sig_frame) begin
            result = 8'h01;
          end else if (!lsb_sig) begin
            result = signed_octet | 8'h02;
          end
        end
        tzs_pkg::TZS_ZCS_FIXED: result = tzs_pkg::FIXED_OCTET;
        default: result = signed_octet;
      endcase
    end
  end
endmodule : tzs_sig_stamp
`default_nettype wire

/* rtl/tzs_tx_conditioner.sv */
// Transmit payload conditioner: serial PCM in, conditioned serial PCM out.
// Assumes bit strobes in the clock domain and an 8-bit indirect register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - All-zero octets leave no long zero runs except under select 00.
// - Select 00 passes octets unchanged.
// - Select 01 forces bit 7 high.
// - Select 10 stuffs LSB, or bit 7.
// - Select 11 substitutes fixed octet 0x98.
// - Superframe signals in frames 6 and 12.
// - Extended superframe signals in 6,12,18,24.
// - Register source replaces signaling-frame LSB.
// - Bit A at 7, B at 6.
// - Superframe two-code uses A twice.
// - Superframe four-code: A frame 6, B 12.
// - Superframe sixteen-code ignores C and D.
// - Extended two-code uses A in all four.
// - Extended four-code: A 6/18, B 12/24.
// - Extended sixteen-code inserts A, B, C, D.
// - Transparent mode leaves LSBs alone.
// - N framing inserts no signaling bits.
// - Sources: registers, external pin, embedded PCM.
// - Bit C at 5, D at 4.
// - Fractional bit selects pin input or timeslot.
module tzs_tx_conditioner (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tx_bit_en,
  input wire logic tx_pcm_serial_in,
  input wire logic frame_sync_in,
  input wire logic [1:0] framing_mode,
  input wire logic ext_signaling_in,
  input wire logic line_ready,
  output logic tx_line_out,
  output logic tx_line_valid,
  output logic tx_timeslot_bit0_out,
  output logic tx_timeslot_bit0_oe_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata
);
  // Serial data, frame sync and signaling inputs pass two flops before use; tx_bit_en is used directly.
  logic [1:0] ser_s_q;
  logic [1:0] sync_s_q;
  logic [1:0] ext_s_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ser_s_q <= '0;
      sync_s_q <= '0;
      ext_s_q <= '0;
    end else begin
      ser_s_q <= {ser_s_q[0], tx_pcm_serial_in};
      sync_s_q <= {sync_s_q[0], frame_sync_in};
      ext_s_q <= {ext_s_q[0], ext_signaling_in};
    end
  end
  wire ser_bit = ser_s_q[1];
  wire sync_bit = sync_s_q[1];
  wire ext_bit = ext_s_q[1];

  // Per-timeslot register files and interface control.
  logic [7:0] chan_ctrl_q [tzs_pkg::NUM_TS];
  logic [7:0] sig_ctrl_q [tzs_pkg::NUM_TS];
  logic [7:0] iface_q;
  logic [7:0] rdata_q;
  wire chan_hit = (reg_addr >= tzs_pkg::CHAN_CTRL_BASE) &&
                  (reg_addr < tzs_pkg::CHAN_CTRL_BASE + 8'(tzs_pkg::NUM_TS));
  wire sig_hit = (reg_addr >= tzs_pkg::SIG_CTRL_BASE) &&
                 (reg_addr < tzs_pkg::SIG_CTRL_BASE + 8'(tzs_pkg::NUM_TS));
  wire if_hit = (reg_addr == tzs_pkg::IFACE_CTRL_ADDR);
  wire [4:0] chan_idx = 5'(reg_addr - tzs_pkg::CHAN_CTRL_BASE);
  wire [4:0] sig_idx = 5'(reg_addr - tzs_pkg::SIG_CTRL_BASE);
  wire [7:0] rd_mux = chan_hit ? chan_ctrl_q[chan_idx] :
                      sig_hit ? sig_ctrl_q[sig_idx] :
                      if_hit ? iface_q : 8'h00;
  genvar g;
  generate
    for (g = 0; g < tzs_pkg::NUM_TS; g++) begin : g_regs
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          chan_ctrl_q[g] <= tzs_pkg::REG_RESET;
          sig_ctrl_q[g] <= tzs_pkg::REG_RESET;
        end else if (reg_wr) begin
          if (chan_hit && chan_idx == 5'(g)) begin
            chan_ctrl_q[g] <= reg_wdata;
          end
          if (sig_hit && sig_idx == 5'(g)) begin
            sig_ctrl_q[g] <= reg_wdata;
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      iface_q <= tzs_pkg::REG_RESET;
      rdata_q <= 8'h00;
    end else begin
      if (reg_wr && if_hit) begin
        iface_q <= reg_wdata;
      end
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign reg_rdata = rdata_q;

  // Deserialiser with timeslot and frame position.
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic [4:0] slot_q;
  logic [4:0] frame_q;
  logic pin_sig_q;
  wire frac = iface_q[tzs_pkg::FRAC_BIT];
  wire [4:0] frame_top = (framing_mode == tzs_pkg::TZS_FMT_ESF) ?
                         5'(tzs_pkg::FRAMES_ESF - 1) : 5'(tzs_pkg::FRAMES_SF - 1);
  wire octet_done = tx_bit_en && (bit_q == 3'd7);
  wire [7:0] octet_full = {shift_q[6:0], ser_bit};
  // External signaling is sampled at the LSB position of each octet.
  wire cap_sig = tx_bit_en && (bit_q == 3'd7) ? ext_bit : pin_sig_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shift_q <= 8'h00;
      bit_q <= 3'd0;
      slot_q <= 5'd0;
      frame_q <= 5'd0;
      pin_sig_q <= 1'b0;
    end else if (tx_bit_en) begin
      shift_q <= octet_full;
      pin_sig_q <= cap_sig;
      if (sync_bit) begin
        bit_q <= 3'd1;
        slot_q <= 5'd0;
        frame_q <= 5'd0;
      end else begin
        bit_q <= bit_q + 3'd1;
        if (bit_q == 3'd7) begin
          if (slot_q == 5'(tzs_pkg::NUM_TS - 1)) begin
            slot_q <= 5'd0;
            frame_q <= (frame_q == frame_top) ? 5'd0 : frame_q + 5'd1;
          end else begin
            slot_q <= slot_q + 5'd1;
          end
        end
      end
    end
  end

  // Buffer between capture and the line; an octet captured while both entries are full is dropped.
  tzs_octet_if cap_if ();
  tzs_octet_if buf_if ();
  assign cap_if.valid = octet_done && !sync_bit;
  assign cap_if.data = octet_full;
  assign cap_if.slot = slot_q;
  assign cap_if.frame = frame_q;
  assign cap_if.sig_bit = ext_bit;
  tzs_skid_buf #(.DEPTH(2), .WIDTH(19)) u_buf (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_if(cap_if),
    .out_if(buf_if)
  );

  wire [7:0] stamped;
  tzs_sig_stamp u_stamp (
    .octet(buf_if.data),
    .frame(buf_if.frame),
    .ext_bit(buf_if.sig_bit),
    .fmt(framing_mode),
    .chan_ctrl(chan_ctrl_q[buf_if.slot]),
    .sig_ctrl(sig_ctrl_q[buf_if.slot]),
    .result(stamped)
  );

  // Output serialiser, MSB first, one bit per accepted line cycle.
  typedef enum logic [1:0] {
    TZS_IDLE = 2'b01,
    TZS_SEND = 2'b10
  } tzs_out_e;
  tzs_out_e st_q;
  logic [7:0] out_sh_q;
  logic [2:0] out_cnt_q;
  logic line_q;
  logic lvalid_q;
  logic ts0_q;
  logic oe_n_q;
  // A new octet waits until the last bit of the previous one has been taken by the line.
  assign buf_if.ready = (st_q == TZS_IDLE) && (line_ready || !lvalid_q);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= TZS_IDLE;
      out_sh_q <= 8'h00;
      out_cnt_q <= 3'd0;
      line_q <= 1'b0;
      lvalid_q <= 1'b0;
    end else begin
      unique case (st_q)
        TZS_IDLE: begin
          if (line_ready || !lvalid_q) begin
            lvalid_q <= 1'b0;
            if (buf_if.valid) begin
              out_sh_q <= stamped;
              out_cnt_q <= 3'd0;
              st_q <= TZS_SEND;
            end
          end
        end
        TZS_SEND: begin
          if (line_ready || !lvalid_q) begin
            line_q <= out_sh_q[7];
            lvalid_q <= 1'b1;
            out_sh_q <= {out_sh_q[6:0], 1'b0};
            out_cnt_q <= out_cnt_q + 3'd1;
            if (out_cnt_q == 3'd7) begin
              st_q <= TZS_IDLE;
            end
          end
        end
      endcase
    end
  end
  // Shared pin: driven with the timeslot LSB unless it serves as signaling input.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ts0_q <= 1'b0;
      oe_n_q <= 1'b0;
    end else begin
      ts0_q <= frac ? 1'b0 : slot_q[0];
      oe_n_q <= frac;
    end
  end
  assign tx_line_out = line_q;
  assign tx_line_valid = lvalid_q;
  assign tx_timeslot_bit0_out = ts0_q;
  assign tx_timeslot_bit0_oe_n = oe_n_q;
endmodule : tzs_tx_conditioner
`default_nettype wire

/* verif/tzs_cond_checker.sv */
// Checker for the conditioner's register port and conditioned line output.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tzs_cond_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic line_ready,
  input wire logic tx_line_out,
  input wire logic tx_line_valid,
  input wire logic tx_timeslot_bit0_out,
  input wire logic tx_timeslot_bit0_oe_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic take;
  logic is_sig;
  logic mapped;
  logic [2:0] bits_q;
  logic [2:0] bits_d;
  logic [4:0] zrun_q;
  logic [4:0] zrun_d;
  assign take = tx_line_valid && line_ready;
  assign is_sig = reg_addr >= 8'h40 && reg_addr <= 8'h57;
  assign mapped = is_sig || reg_addr <= 8'h17 || reg_addr == 8'h20;
  assign bits_d = take ? bits_q + 3'h1 : bits_q;
  assign zrun_d = !take ? zrun_q : tx_line_out ? 5'h00 : zrun_q + 5'h01;
  always_ff @(posedge clock) begin
    bits_q <= sys_rst ? 3'h0 : bits_d;
    zrun_q <= sys_rst ? 5'h00 : zrun_d;
  end
  sequence sig_wr_rd;
    reg_wr && is_sig ##2 reg_rd && reg_addr == $past(reg_addr, 2);
  endsequence
  sig_readback_a: assert property (sig_wr_rd |=> reg_rdata[7:4] == $past(reg_wdata[7:4], 3))
    else $error("signaling bits not read back");
  unmapped_read_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_stand_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  reset_quiet_a: assert property ($fell(sys_rst) |-> !tx_line_valid && !tx_timeslot_bit0_oe_n)
    else $error("outputs not quiet after reset");
  pin_idle_a: assert property (tx_timeslot_bit0_oe_n |-> !tx_timeslot_bit0_out)
    else $error("pin driven while an input");
  bit_hold_a: assert property (tx_line_valid && !line_ready |=> tx_line_valid && $stable(tx_line_out))
    else $error("line bit dropped during stall");
  octet_gap_a: assert property (take && bits_q == 3'h7 |=> !tx_line_valid)
    else $error("no idle cycle after octet");
  octet_start_a: assert property ($rose(tx_line_valid) |-> bits_q == 3'h0)
    else $error("octet started mid count");
  zero_run_a: assert property (zrun_q <= 5'h0f)
    else $error("zero run too long");
endmodule : tzs_cond_checker
bind tzs_tx_conditioner tzs_cond_checker u_checker (.*);
`default_nettype wire

/* verif/tzs_pcm_source.sv */
// Terminal equipment model: serial PCM, frame sync, bit strobe and signaling pin.
// Assumes run rises only after the block has been reset and configured.
`timescale 1ns/1ps
`default_nettype none
module tzs_pcm_source (
  input wire logic clock,
  input wire logic run,
  output logic tx_bit_en,
  output logic tx_pcm_serial_in,
  output logic frame_sync_in,
  output logic ext_signaling_in
);
  int ph = 0;
  int bi = 0;
  int sl = 0;
  int fr = 1;
  logic [7:0] oct;
  initial begin
    {tx_bit_en, tx_pcm_serial_in, frame_sync_in, ext_signaling_in} = 4'h0;
  end
  // Each bit is held four cycles so the two-flop synchronisers settle before the strobe.
  always @(negedge clock) begin
    if (!run) begin
      ph = 0;
      bi = 0;
      sl = 0;
      fr = 1;
      tx_bit_en <= 1'b0;
    end else begin
      oct = sl % 3 == 0 ? 8'h00 : sl % 3 == 1 ? 8'h5a : 8'ha5;
      tx_pcm_serial_in <= oct[7 - bi];
      frame_sync_in <= fr == 1 && sl == 0 && bi == 0;
      ext_signaling_in <= fr[0] ^ sl[0];
      tx_bit_en <= ph == 3;
      if (ph == 3) begin
        bi = (bi + 1) % 8;
        if (bi == 0) sl = (sl + 1) % 24;
        if (bi == 0 && sl == 0) fr = fr % 24 + 1;
      end
      ph = (ph + 1) % 4;
    end
  end
endmodule : tzs_pcm_source
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench: register tasks, then EXTENDED_SUPERFRAME_FORMAT, SF and N payload runs.
// Assumes the terminal equipment model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b0;
  logic line_ready = 1'b1;
  logic [1:0] framing_mode = 2'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic tx_bit_en, tx_pcm_serial_in, frame_sync_in, ext_signaling_in;
  logic tx_line_out, tx_line_valid, tx_timeslot_bit0_out, tx_timeslot_bit0_oe_n;
  logic [7:0] reg_rdata;
  logic [7:0] sh;
  logic [7:0] ua [6] = '{8'h05, 8'h20, 8'h45, 8'h18, 8'h30, 8'h58};
  int fails = 0;
  int comparisons = 0;
  int k = 0;
  int nb = 0;
  int cyc = 0;
  tzs_tx_conditioner u_dut (.*);
  tzs_pcm_source u_te (.*);
  always #5 clock = ~clock;
  // Long stalls leave at most one octet waiting in the two-entry buffer, so it never fills or overruns.
  always @(negedge clock) begin
    cyc++;
    line_ready <= cyc % 1024 >= 40 && cyc % 4 != 0;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [7:0] g;
    wr(a, d);
    rd(a, g);
    check(g, e);
  endtask : wrc
  function automatic logic [1:0] src_of(int s);
    return s >= 22 ? tzs_pkg::SRC_PCM : s >= 20 ? tzs_pkg::SRC_PIN : tzs_pkg::SRC_REG;
  endfunction : src_of
  function automatic logic [3:0] nib(int s, int m);
    logic [3:0] r;
    r = s[3:0] ^ 4'h6;
    return m == 1 ? {4{r[3]}} : m == 2 ? {r[3:2], r[3:2]} : r;
  endfunction : nib
  function automatic logic [7:0] exp_oct(int n);
    int s;
    int f;
    int m;
    int i;
    logic [3:0] r;
    logic [7:0] p;
    logic [7:0] o;
    logic b;
    logic ins;
    s = n % 24;
    f = framing_mode == 2'h1 ? n / 24 % 12 + 1 : n / 24 % 24 + 1;
    m = s / 3 % 4;
    r = nib(s, m);
    i = m == 1 ? 0 : m == 2 ? (f / 6 - 1) % 2 : f / 6 - 1;
    b = src_of(s) == tzs_pkg::SRC_PIN ? f[0] ^ s[0] : r[3 - i];
    p = s % 3 == 0 ? 8'h00 : s % 3 == 1 ? 8'h5a : 8'ha5;
    ins = framing_mode != 2'h0 && f % 6 == 0 && m != 0 && src_of(s) != tzs_pkg::SRC_PCM;
    o = ins ? {p[7:1], b} : p;
    if (p == 8'h00 && framing_mode != 2'h0) begin
      case (s % 4)
        1: o = o | 8'h02;
        2: o = ins ? {6'h00, !b, b} : 8'h01;
        3: o = 8'h98;
        default: o = o;
      endcase
    end
    return o;
  endfunction : exp_oct
  task automatic run_phase(input logic [1:0] fm, input int n);
    logic [7:0] c;
    int m;
    @(negedge clock);
    run = 1'b0;
    sys_rst = 1'b1;
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    framing_mode = fm;
    for (int s = 0; s < 24; s++) begin
      m = s / 3 % 4;
      c = {2'h0, fm == 2'h0 ? 2'h0 : 2'(s % 4), 4'h0};
      wrc(8'(s), c, c);
      c = {nib(s, m), src_of(s), 2'(m)};
      wrc(8'h40 + 8'(s), c, c);
    end
    c = {3'h0, fm != 2'h0, 4'h0};
    wrc(8'h20, c, c);
    repeat (4) @(negedge clock);
    check({7'h00, tx_timeslot_bit0_oe_n}, {7'h00, fm != 2'h0});
    run = 1'b1;
    for (int j = 0; j < n * 40 && k < n; j++) @(posedge clock);
    if (k < n) fails++;
  endtask : run_phase
  task automatic conclude();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge clock) begin
    if (sys_rst) begin
      k = 0;
      nb = 0;
    end else begin
      if (tx_line_valid === 1'b1 && line_ready) begin
        sh = {sh[6:0], tx_line_out};
        nb = (nb + 1) % 8;
        if (nb == 0) begin
          check(sh, exp_oct(k));
          k++;
        end
      end
      // Mid-octet, the pin shows the LSB of the slot being fed, or zero as an input.
      if (run && u_te.bi == 4 && u_te.ph == 2) begin
        check({7'h00, tx_timeslot_bit0_out}, {7'h00, framing_mode == 2'h0 && u_te.sl % 2 == 1});
      end
    end
  end
  initial begin
    logic [7:0] g;
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    foreach (ua[j]) begin
      rd(ua[j], g);
      check(g, 8'h00);
    end
    for (int j = 3; j < 6; j++) wrc(ua[j], 8'hff, 8'h00);
    run_phase(2'h2, 576);
    run_phase(2'h1, 288);
    run_phase(2'h0, 48);
    conclude();
  end
  initial begin
    #400000;
    fails++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
